/* inc/rbm_pkg.sv */
// Package for the radio buffer pointer and event mask register bank.
// Assumes an 8-bit register port with 7-bit addresses.
package rbm_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam logic [6:0] OFS_RX_AMP = 7'h0c;
  localparam logic [6:0] OFS_BUF_PTR = 7'h0d;
  localparam logic [6:0] OFS_TX_START = 7'h0e;
  localparam logic [6:0] OFS_RX_START = 7'h0f;
  localparam logic [6:0] OFS_LAST_START = 7'h10;
  localparam logic [6:0] OFS_EVT_MASK = 7'h11;
  localparam logic [6:0] OFS_EVT_FLAGS = 7'h12;
  localparam logic [6:0] OFS_RX_LEN = 7'h13;
  localparam logic [6:0] OFS_BUF_DATA = 7'h00;
  localparam int GAIN_HI = 7;
  localparam int GAIN_LO = 5;
  localparam int LBIAS_HI = 4;
  localparam int LBIAS_LO = 3;
  localparam int RSV_BIT = 2;
  localparam int HBIAS_HI = 1;
  localparam int HBIAS_LO = 0;
  localparam logic [2:0] GAIN_RST = 3'h1;
  localparam logic [2:0] GAIN_MAX = 3'h1;
  localparam logic [2:0] GAIN_MIN = 3'h6;
  localparam logic [1:0] BIAS_DEFAULT = 2'h0;
  localparam logic [1:0] BIAS_BOOST = 2'h3;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] TX_START_RST = 8'h80;
  localparam logic [7:0] RX_START_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [7:0] ONE8 = 8'h01;
  // Event bit positions, shared by flags and mask
  localparam int EV_RX_TIMEOUT = 7;
  localparam int EV_RX_DONE = 6;
  localparam int EV_CHECK_FAIL = 5;
  localparam int EV_HEADER_OK = 4;
  localparam int EV_TX_DONE = 3;
  localparam int EV_SCAN_DONE = 2;
  localparam int EV_HOP = 1;
  localparam int EV_FOUND = 0;
endpackage

/* logic/rbm_regs.sv */
// Register bank: amplifier control, buffer pointers, event flags and mask.
// Assumes the serial port decoder delivers one-cycle read/write strobes.
`timescale 1ns/100ps
module rbm_regs (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port from serial decoder
  input wire logic [rbm_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [rbm_pkg::DATA_W-1:0] reg_wdata,
  output logic [rbm_pkg::DATA_W-1:0] reg_rdata,
  // Buffer data port towards the packet memory
  output logic [7:0] buf_addr,
  output logic buf_wr,
  output logic buf_rd,
  output logic [7:0] buf_wdata,
  input wire logic [7:0] buf_rdata,
  // Modem side
  input wire logic [7:0] modem_events,
  input wire logic rx_packet_done,
  input wire logic [7:0] rx_packet_start,
  input wire logic [7:0] rx_packet_len,
  output logic [7:0] transmit_buffer_start,
  output logic [7:0] receive_buffer_start,
  output logic [2:0] rx_amp_gain,
  output logic [1:0] low_band_amp_bias,
  output logic high_band_boost,
  // Interrupt to host
  output logic irq
);
  import rbm_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [2:0] gain_r;
  logic [1:0] lbias_r;
  logic rsv_r;
  logic [1:0] hbias_r;
  logic [7:0] ptr_r;
  logic [7:0] tx_start_r;
  logic [7:0] rx_start_r;
  logic [7:0] last_start_r;
  logic [7:0] rx_len_r;
  logic [7:0] mask_r;
  logic [7:0] flags_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic data_port;
  logic data_access;
  logic wr_amp;
  logic wr_ptr;
  logic wr_tx;
  logic wr_rx;
  logic wr_mask;
  logic wr_flags;

  ////////////////////////////////////////////////////////////////////////
  // Write decode
  assign data_port = (reg_addr == OFS_BUF_DATA);
  assign data_access = (reg_wr || reg_rd) && data_port;
  assign wr_amp = reg_wr && (reg_addr == OFS_RX_AMP);
  assign wr_ptr = reg_wr && (reg_addr == OFS_BUF_PTR);
  assign wr_tx = reg_wr && (reg_addr == OFS_TX_START);
  assign wr_rx = reg_wr && (reg_addr == OFS_RX_START);
  assign wr_mask = reg_wr && (reg_addr == OFS_EVT_MASK);
  assign wr_flags = reg_wr && (reg_addr == OFS_EVT_FLAGS);

  ////////////////////////////////////////////////////////////////////////
  // Amplifier control
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      gain_r <= GAIN_RST;
    end else if (wr_amp) begin
      gain_r <= reg_wdata[GAIN_HI:GAIN_LO];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lbias_r <= BIAS_DEFAULT;
    end else if (wr_amp) begin
      lbias_r <= reg_wdata[LBIAS_HI:LBIAS_LO];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rsv_r <= 1'b0;
    end else if (wr_amp) begin
      rsv_r <= reg_wdata[RSV_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hbias_r <= BIAS_DEFAULT;
    end else if (wr_amp) begin
      hbias_r <= reg_wdata[HBIAS_HI:HBIAS_LO];
    end
  end

  assign rx_amp_gain = gain_r;
  assign low_band_amp_bias = lbias_r;
  assign high_band_boost = (hbias_r == BIAS_BOOST);

  ////////////////////////////////////////////////////////////////////////
  // Buffer pointers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ptr_r <= PTR_RST;
    end else if (wr_ptr) begin
      ptr_r <= reg_wdata;
    end else if (data_access) begin
      ptr_r <= ptr_r + ONE8;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_start_r <= TX_START_RST;
    end else if (wr_tx) begin
      tx_start_r <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_start_r <= RX_START_RST;
    end else if (wr_rx) begin
      rx_start_r <= reg_wdata;
    end
  end

  assign transmit_buffer_start = tx_start_r;
  assign receive_buffer_start = rx_start_r;

  // Last packet details, modem writes only
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      last_start_r <= ZERO8;
      rx_len_r <= ZERO8;
    end else if (rx_packet_done) begin
      last_start_r <= rx_packet_start;
      rx_len_r <= rx_packet_len;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Buffer data port, address is the access pointer
  assign buf_addr = ptr_r;
  assign buf_wr = reg_wr && data_port;
  assign buf_rd = reg_rd && data_port;
  assign buf_wdata = reg_wdata;

  ////////////////////////////////////////////////////////////////////////
  // Event mask and flags
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mask_r <= MASK_RST;
    end else if (wr_mask) begin
      mask_r <= reg_wdata;
    end
  end

  // Per event bit, new events win over a simultaneous clear
  for (genvar i = 0; i < DATA_W; i++) begin : g_flag
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        flags_r[i] <= 1'b0;
      end else if (modem_events[i]) begin
        flags_r[i] <= 1'b1;
      end else if (wr_flags && reg_wdata[i]) begin
        flags_r[i] <= 1'b0;
      end
    end
  end

  assign irq = |(flags_r & ~mask_r);

  ////////////////////////////////////////////////////////////////////////
  // Read select
  always_comb begin
    rdata_nxt = ZERO8;
    case (reg_addr)
      OFS_BUF_DATA: rdata_nxt = buf_rdata;
      OFS_RX_AMP: rdata_nxt = {gain_r, lbias_r, rsv_r, hbias_r};
      OFS_BUF_PTR: rdata_nxt = ptr_r;
      OFS_TX_START: rdata_nxt = tx_start_r;
      OFS_RX_START: rdata_nxt = rx_start_r;
      OFS_LAST_START: rdata_nxt = last_start_r;
      OFS_EVT_MASK: rdata_nxt = mask_r;
      OFS_EVT_FLAGS: rdata_nxt = flags_r;
      OFS_RX_LEN: rdata_nxt = rx_len_r;
      default: rdata_nxt = ZERO8;
    endcase
  end

  // Read data, registered one cycle after the read strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_r <= ZERO8;
    end else if (reg_rd) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
endmodule

/* verification/rbm_regs_properties.sv */
// Port checker for the register bank.
// Assumes binding onto rbm_regs.
`timescale 1ns/100ps
module rbm_regs_chk (
  // Watched ports
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [6:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] buf_addr,
  input wire logic buf_rd,
  input wire logic [7:0] buf_rdata,
  input wire logic [7:0] transmit_buffer_start,
  input wire logic [2:0] rx_amp_gain,
  input wire logic high_band_boost
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence wr_s(a); reg_wr && reg_addr == a; endsequence
  sequence rd_s(a); reg_rd && reg_addr == a; endsequence
  gain_wr_a: assert property (wr_s(7'h0c) |=>
    rx_amp_gain == $past(reg_wdata[7:5])) else $error("gain");
  boost_wr_a: assert property (wr_s(7'h0c) |=>
    high_band_boost == ($past(reg_wdata[1:0]) == 2'h3))
    else $error("boost");
  tx_wr_a: assert property (wr_s(7'h0e) |=>
    transmit_buffer_start == $past(reg_wdata)) else $error("tx start");
  ptr_wr_a: assert property (wr_s(7'h0d) |=>
    buf_addr == $past(reg_wdata)) else $error("pointer write");
  ptr_rd_a: assert property (rd_s(7'h0d) |=>
    reg_rdata == $past(buf_addr)) else $error("pointer read");
  data_rd_a: assert property (rd_s(7'h00) |=>
    reg_rdata == $past(buf_rdata)) else $error("data read");
  ptr_step_a: assert property (buf_rd |=>
    buf_addr == $past(buf_addr) + 8'h01) else $error("pointer step");
  reset_val_a: assert property (disable iff (1'b0) rst |=>
    transmit_buffer_start == 8'h80 && rx_amp_gain == 3'h1)
    else $error("reset");
endmodule
bind rbm_regs rbm_regs_chk chk (.*);

/* verification/rbm_buf_model.sv */
// Packet buffer model on the buffer data port.
// Assumes reads are sampled in the cycle of buf_rd.
`timescale 1ns/100ps
module rbm_buf_model (
  // Buffer port
  input wire logic ref_clk,
  input wire logic [7:0] buf_addr,
  input wire logic buf_wr,
  input wire logic buf_rd,
  input wire logic [7:0] buf_wdata,
  output logic [7:0] buf_rdata
);
  logic [7:0] mem_r [256];
  // Unselected data shows the inverse
  assign buf_rdata = buf_rd ? mem_r[buf_addr] : ~mem_r[buf_addr];
  always_ff @(posedge ref_clk) begin
    if (buf_wr) mem_r[buf_addr] <= buf_wdata;
  end
endmodule

/* verification/rbm_regs_bench.sv */
// Self-checking bench for the register bank.
// Assumes the buffer model and the bound checker.
`timescale 1ns/100ps
module rbm_regs_bench;
  import rbm_pkg::*;
  logic ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, rx_packet_done = 0;
  logic [6:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, modem_events = 0, rx_packet_start = 0;
  logic [7:0] rx_packet_len = 0, reg_rdata, buf_addr, buf_wdata, buf_rdata;
  logic [7:0] transmit_buffer_start, receive_buffer_start, d, e;
  logic [2:0] rx_amp_gain;
  logic [1:0] low_band_amp_bias;
  logic buf_wr, buf_rd, high_band_boost, irq;
  int num_errors = 0, comparisons = 0, seed = 32'h3396;
  always #2.5 ref_clk = ~ref_clk;
  rbm_regs dut (.*);
  rbm_buf_model mem (.*);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    @(negedge ref_clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, v};
    @(negedge ref_clk) reg_wr = 0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] x);
    @(negedge ref_clk) {reg_rd, reg_addr} = {1'b1, a};
    @(negedge ref_clk) reg_rd = 0;
    chk(reg_rdata, x);
  endtask
  task automatic print_verdict;
    if (num_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge ref_clk);
    rst = 0;
    for (int a = 12; a < 18; a++) rd(7'(a), a == 12 ? 8'h20 :
      a == 14 ? 8'h80 : 8'h00);
    repeat (6) begin
      d = $random(seed);
      e = {d[7:5], 2'h0, d[2:0]};
      wr(OFS_RX_AMP, e);
      rd(OFS_RX_AMP, e);
      chk({rx_amp_gain, low_band_amp_bias, 2'h0, high_band_boost},
        {d[7:5], 4'h0, d[1:0] == 2'h3});
      wr(OFS_TX_START, d);
      wr(OFS_RX_START, ~d);
      wr(OFS_EVT_MASK, d);
      wr(OFS_LAST_START, d);
      chk(transmit_buffer_start, d);
      chk(receive_buffer_start, ~d);
      rd(OFS_EVT_MASK, d);
      rd(OFS_LAST_START, 8'h00);
    end
    wr(OFS_BUF_PTR, 8'hff);
    wr(OFS_BUF_DATA, d);
    rd(OFS_BUF_PTR, 8'h00);
    wr(OFS_BUF_PTR, 8'hff);
    rd(OFS_BUF_DATA, d);
    @(negedge ref_clk) {rx_packet_done, rx_packet_start, rx_packet_len} =
      {1'b1, d, ~d};
    @(negedge ref_clk) rx_packet_done = 0;
    rd(OFS_LAST_START, d);
    rd(OFS_RX_LEN, ~d);
    wr(OFS_EVT_MASK, 8'h00);
    for (int i = 0; i < 8; i++) begin
      d = 8'h01 << i;
      @(negedge ref_clk) modem_events = d;
      @(negedge ref_clk) modem_events = 0;
      rd(OFS_EVT_FLAGS, d);
      chk({7'h0, irq}, 8'h01);
      wr(OFS_EVT_MASK, d);
      @(negedge ref_clk) chk({7'h0, irq}, 8'h00);
      wr(OFS_EVT_FLAGS, d);
      wr(OFS_EVT_MASK, 8'h00);
      rd(OFS_EVT_FLAGS, 8'h00);
    end
    @(negedge ref_clk) {modem_events, reg_wr, reg_addr, reg_wdata} =
      {8'h04, 1'b1, OFS_EVT_FLAGS, 8'h04};
    @(negedge ref_clk) {modem_events, reg_wr} = 9'h000;
    rd(OFS_EVT_FLAGS, 8'h04);
    wr(OFS_BUF_PTR, d);
    @(negedge ref_clk) rst = 1;
    repeat (3) @(negedge ref_clk);
    rst = 0;
    rd(OFS_BUF_PTR, 8'h00);
    rd(OFS_EVT_FLAGS, 8'h00);
    rd(OFS_RX_AMP, 8'h20);
    chk(transmit_buffer_start, 8'h80);
    chk({7'h0, irq}, 8'h00);
    print_verdict;
  end
endmodule
